//--- light_prox_interrupt_regs.sv
// How it works
// - Near persistence code selects 1,2,4,8 events.
// - Light persistence code selects 1,2,4,8 events.
// - Bit 0 selects AND or OR pin combine.
// - Bit 7 shows pending near event.
// - Bit 3 shows pending light event.
// - Bit 4 set on supply brown-out.
// - Brown-out never drives the interrupt pin.
// - Writing 0 to bit 4 clears brown-out.
// - Near thresholds at 0x05/0x06, reset 00/ff.
// - Light thresholds packed across three bytes.
// - Light threshold bytes reset 00, 0f, ff.
// - Near result readable at 0x0a.
// - Light result split over 0x0b and 0x0c.
// - Light high byte upper nibble reads zero.
// - 0x0d bits 7:1 hold ambient IR.
// - 0x0d bit 0 is the washout flag.
// - Writing 0x38 to 0x0e starts software reset.
// - Light flag when count outside thresholds.
// - Near flag when count above high threshold.
// - Hysteresis mode clears near flag below low.
// - Pin asserts after consecutive flagged measurements.
module light_prox_interrupt_regs
	import light_prox_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDRESS = 7'h2a // Arbitrary value.
)
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Two-wire serial bus
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	// Interrupt pin, open drain, active low
	output logic             int_o,
	output logic             int_oe_o,
	// Conversion results from the measurement logic
	input  wire logic        near_valid_i,
	input  wire logic [7:0]  near_result_i,
	input  wire logic [6:0]  ambient_ir_level_i,
	input  wire logic        washout_flag_i,
	input  wire logic        near_window_mode_i,
	input  wire logic        light_valid_i,
	input  wire logic [11:0] light_result_i,
	// Supply monitor
	input  wire logic        brownout_i
);

	logic          scl_meta, scl_sync, scl_prev;
	logic          sda_meta, sda_sync, sda_prev;
	logic          bo_meta, bo_sync;
	logic          scl_rise, scl_fall, bus_start, bus_stop;
	bus_state_type state;
	logic [3:0]    bit_cnt;
	logic [7:0]    shift;
	logic [7:0]    pointer;
	logic          first_byte, read_dir, master_ack;
	logic          wr_en;
	logic [7:0]    wr_data;
	logic [7:0]    rd_data;

	logic [7:0]    int_cfg;
	logic [7:0]    near_low_threshold, near_high_threshold;
	logic [7:0]    light_low_thr_upper_bits, light_shared, light_high_thr_lower_bits;
	logic [7:0]    software_reset_ctrl;
	logic [7:0]    near_result;
	logic [11:0]   light_result;
	logic [6:0]    ambient_ir_level;
	logic          washout_flag;
	logic [3:0]    near_cnt, light_cnt;
	logic          soft_rst;

	logic [11:0]   light_low, light_high;
	logic [3:0]    near_need, light_need, next_near_cnt, next_light_cnt;
	logic          near_hit, light_hit, near_set, light_set, near_auto_clr;
	logic          cfg_wr, near_event_flag, light_event_flag, brownout_flag;

	assign soft_rst = (software_reset_ctrl == SOFTWARE_RESET_CODE);

	// Two-stage synchronisers; the edge detectors compare the second stage with a third, delayed stage.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			{scl_meta, scl_sync, scl_prev} <= 3'h7;
			{sda_meta, sda_sync, sda_prev} <= 3'h7;
			{bo_meta, bo_sync}             <= 2'h0;
		end
		else
		begin
			{scl_meta, scl_sync, scl_prev} <= {scl_i, scl_meta, scl_sync};
			{sda_meta, sda_sync, sda_prev} <= {sda_i, sda_meta, sda_sync};
			{bo_meta, bo_sync}             <= {brownout_i, bo_meta};
		end
	end

	assign scl_rise  = scl_sync & ~scl_prev;
	assign scl_fall  = ~scl_sync & scl_prev;
	assign bus_start = scl_sync & scl_prev & ~sda_sync & sda_prev;
	assign bus_stop  = scl_sync & scl_prev & sda_sync & ~sda_prev;
	assign wr_en     = (state == ST_WRITE) && scl_fall && (bit_cnt == BITS_PER_BYTE) && !first_byte;
	assign wr_data   = shift;

	// Read multiplexer; unmapped offsets read as zero.
	always_comb
	begin
		case (pointer)
			OFS_INT_CFG_STATUS:  rd_data = int_cfg;
			OFS_NEAR_LOW_THR:    rd_data = near_low_threshold;
			OFS_NEAR_HIGH_THR:   rd_data = near_high_threshold;
			OFS_LIGHT_LOW_UPPER: rd_data = light_low_thr_upper_bits;
			OFS_LIGHT_SHARED:    rd_data = light_shared;
			OFS_LIGHT_HIGH_LOW:  rd_data = light_high_thr_lower_bits;
			OFS_NEAR_RESULT:     rd_data = near_result;
			OFS_LIGHT_RES_HIGH:  rd_data = {4'h0, light_result[11:8]};
			OFS_LIGHT_RES_LOW:   rd_data = light_result[7:0];
			OFS_AMBIENT_IR:      rd_data = {ambient_ir_level, washout_flag};
			OFS_SW_RESET_CTRL:   rd_data = software_reset_ctrl;
			default:             rd_data = 8'h00;
		endcase
	end

	// Serial bus slave: address, register pointer, auto-incremented data.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			shift      <= 8'h00;
			pointer    <= 8'h00;
			first_byte <= 1'b0;
			read_dir   <= 1'b0;
			master_ack <= 1'b0;
			sda_oe_o   <= 1'b0;
		end
		else if (bus_start)
		begin
			state      <= ST_ADDR;
			bit_cnt    <= 4'h0;
			first_byte <= 1'b1;
			sda_oe_o   <= 1'b0;
		end
		else if (bus_stop)
		begin
			state    <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end
		else
		begin
			case (state)
				ST_ADDR, ST_WRITE:
				begin
					if (scl_rise)
					begin
						shift   <= {shift[6:0], sda_sync};
						bit_cnt <= bit_cnt + 4'h1;
					end
					else if (scl_fall && bit_cnt == BITS_PER_BYTE)
					begin
						if (state == ST_ADDR)
						begin
							if (shift[7:1] == DEVICE_ADDRESS)
							begin
								state    <= ST_ADDR_ACK;
								read_dir <= shift[0];
								sda_oe_o <= 1'b1;
							end
							else
								state <= ST_IDLE;
						end
						else
						begin
							state    <= ST_WRITE_ACK;
							sda_oe_o <= 1'b1;
							if (first_byte)
							begin
								pointer    <= shift;
								first_byte <= 1'b0;
							end
							else
								pointer <= pointer + 8'h01;
						end
					end
				end
				ST_ADDR_ACK, ST_WRITE_ACK:
				begin
					if (scl_fall)
					begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR_ACK && read_dir)
						begin
							state    <= ST_READ;
							shift    <= {rd_data[6:0], 1'b0};
							sda_oe_o <= ~rd_data[7];
							pointer  <= pointer + 8'h01;
						end
						else
						begin
							state    <= ST_WRITE;
							sda_oe_o <= 1'b0;
						end
					end
				end
				ST_READ:
				begin
					if (scl_rise)
						bit_cnt <= bit_cnt + 4'h1;
					else if (scl_fall)
					begin
						if (bit_cnt == BITS_PER_BYTE)
						begin
							state    <= ST_READ_ACK;
							sda_oe_o <= 1'b0;
						end
						else
						begin
							sda_oe_o <= ~shift[7];
							shift    <= {shift[6:0], 1'b0};
						end
					end
				end
				ST_READ_ACK:
				begin
					if (scl_rise)
						master_ack <= ~sda_sync;
					else if (scl_fall)
					begin
						bit_cnt <= 4'h0;
						if (master_ack)
						begin
							state    <= ST_READ;
							shift    <= {rd_data[6:0], 1'b0};
							sda_oe_o <= ~rd_data[7];
							pointer  <= pointer + 8'h01;
						end
						else
							state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign sda_o = 1'b0;

	// Threshold unpacking and flag conditions.
	assign light_low  = {light_low_thr_upper_bits, light_shared[7:4]};
	assign light_high = {light_shared[3:0], light_high_thr_lower_bits};
	assign near_need  = 4'h1 << int_cfg[BIT_NEAR_PERS_HI:BIT_NEAR_PERS_LO];
	assign light_need = 4'h1 << int_cfg[BIT_LIGHT_PERS_HI:BIT_LIGHT_PERS_LO];
	assign near_hit   = (near_result_i > near_high_threshold) ||
	                    (near_window_mode_i && near_result_i < near_low_threshold);
	assign light_hit  = (light_result_i < light_low) || (light_result_i > light_high);
	assign next_near_cnt  = !near_hit ? 4'h0 :
	                        (near_cnt == PERSIST_MAX) ? near_cnt : near_cnt + 4'h1;
	assign next_light_cnt = !light_hit ? 4'h0 :
	                        (light_cnt == PERSIST_MAX) ? light_cnt : light_cnt + 4'h1;
	assign near_set   = near_valid_i && near_hit && (next_near_cnt >= near_need);
	assign light_set  = light_valid_i && light_hit && (next_light_cnt >= light_need);
	assign near_auto_clr = near_valid_i && !near_window_mode_i &&
	                       (near_result_i < near_low_threshold);
	assign cfg_wr     = wr_en && (pointer == OFS_INT_CFG_STATUS);
	assign near_event_flag  = int_cfg[BIT_NEAR_FLAG];
	assign light_event_flag = int_cfg[BIT_LIGHT_FLAG];
	assign brownout_flag    = int_cfg[BIT_BROWNOUT];

	// Per-channel consecutive event counters.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			near_cnt  <= 4'h0;
			light_cnt <= 4'h0;
		end
		else if (soft_rst)
		begin
			near_cnt  <= 4'h0;
			light_cnt <= 4'h0;
		end
		else
		begin
			if (near_valid_i)
				near_cnt <= next_near_cnt;
			if (light_valid_i)
				light_cnt <= next_light_cnt;
		end
	end

	// Interrupt configuration and status; a hardware set wins over a clear.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			int_cfg <= RST_INT_CFG_STATUS;
		else if (soft_rst)
			int_cfg <= RST_INT_CFG_STATUS;
		else
		begin
			if (cfg_wr)
			begin
				int_cfg[BIT_NEAR_PERS_HI:BIT_NEAR_PERS_LO]   <= wr_data[BIT_NEAR_PERS_HI:BIT_NEAR_PERS_LO];
				int_cfg[BIT_LIGHT_PERS_HI:BIT_LIGHT_PERS_LO] <= wr_data[BIT_LIGHT_PERS_HI:BIT_LIGHT_PERS_LO];
				int_cfg[BIT_COMBINE_AND] <= wr_data[BIT_COMBINE_AND];
			end
			if (near_set)
				int_cfg[BIT_NEAR_FLAG] <= 1'b1;
			else if (near_auto_clr || (cfg_wr && !wr_data[BIT_NEAR_FLAG]))
				int_cfg[BIT_NEAR_FLAG] <= 1'b0;
			if (light_set)
				int_cfg[BIT_LIGHT_FLAG] <= 1'b1;
			else if (cfg_wr && !wr_data[BIT_LIGHT_FLAG])
				int_cfg[BIT_LIGHT_FLAG] <= 1'b0;
			if (bo_sync)
				int_cfg[BIT_BROWNOUT] <= 1'b1;
			else if (cfg_wr && !wr_data[BIT_BROWNOUT])
				int_cfg[BIT_BROWNOUT] <= 1'b0;
		end
	end

	// Threshold and software reset registers.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			near_low_threshold        <= RST_NEAR_LOW_THR;
			near_high_threshold       <= RST_NEAR_HIGH_THR;
			light_low_thr_upper_bits  <= RST_LIGHT_LOW_UPPER;
			light_shared              <= RST_LIGHT_SHARED;
			light_high_thr_lower_bits <= RST_LIGHT_HIGH_LOW;
			software_reset_ctrl       <= RST_SW_RESET_CTRL;
		end
		else if (soft_rst)
		begin
			near_low_threshold        <= RST_NEAR_LOW_THR;
			near_high_threshold       <= RST_NEAR_HIGH_THR;
			light_low_thr_upper_bits  <= RST_LIGHT_LOW_UPPER;
			light_shared              <= RST_LIGHT_SHARED;
			light_high_thr_lower_bits <= RST_LIGHT_HIGH_LOW;
			software_reset_ctrl       <= RST_SW_RESET_CTRL;
		end
		else if (wr_en)
		begin
			case (pointer)
				OFS_NEAR_LOW_THR:    near_low_threshold        <= wr_data;
				OFS_NEAR_HIGH_THR:   near_high_threshold       <= wr_data;
				OFS_LIGHT_LOW_UPPER: light_low_thr_upper_bits  <= wr_data;
				OFS_LIGHT_SHARED:    light_shared              <= wr_data;
				OFS_LIGHT_HIGH_LOW:  light_high_thr_lower_bits <= wr_data;
				OFS_SW_RESET_CTRL:   software_reset_ctrl       <= wr_data;
				default:             software_reset_ctrl       <= software_reset_ctrl;
			endcase
		end
	end

	// Latest conversion results.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			near_result      <= RST_RESULT;
			light_result     <= 12'h000;
			ambient_ir_level <= 7'h00;
			washout_flag     <= 1'b0;
		end
		else if (soft_rst)
		begin
			near_result      <= RST_RESULT;
			light_result     <= 12'h000;
			ambient_ir_level <= 7'h00;
			washout_flag     <= 1'b0;
		end
		else
		begin
			if (near_valid_i)
			begin
				near_result      <= near_result_i;
				ambient_ir_level <= ambient_ir_level_i;
				washout_flag     <= washout_flag_i;
			end
			if (light_valid_i)
				light_result <= light_result_i;
		end
	end

	// The brown-out flag takes no part in the pin.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			int_oe_o <= 1'b0;
		else if (int_cfg[BIT_COMBINE_AND])
			int_oe_o <= near_event_flag & light_event_flag;
		else
			int_oe_o <= near_event_flag | light_event_flag;
	end

	assign int_o = 1'b0;

endmodule // light_prox_interrupt_regs

//--- light_prox_interrupt_regs_monitor.sv
module light_prox_interrupt_regs_monitor
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Serial bus
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Interrupt, strobes and supply
	input wire logic int_o,
	input wire logic int_oe_o,
	input wire logic near_valid_i,
	input wire logic light_valid_i,
	input wire logic brownout_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	// No strobe and no byte being acknowledged, so nothing may move the pin.
	sequence no_cause;
		!near_valid_i && !light_valid_i && !sda_oe_o;
	endsequence
	// The pin follows a flag one cycle after the strobe edge or a register write.
	sequence rise_cause;
		$past(near_valid_i, 2) || $past(light_valid_i, 2) || sda_oe_o;
	endsequence

	chk_int_rise_cause: assert property ($rose(int_oe_o) |-> rise_cause)
		else $error("interrupt asserted with no strobe or write");
	chk_int_fall_cause: assert property ($fell(int_oe_o) |-> $past(near_valid_i, 2) || sda_oe_o)
		else $error("interrupt released with no clear");
	chk_int_quiet_hold: assert property (no_cause[*3] |=> $stable(int_oe_o))
		else $error("interrupt moved while quiet");
	// A brown-out reaches the flag after about three cycles, so the pin is watched for eight.
	chk_brownout_no_int: assert property (no_cause ##1 ($rose(brownout_i) && !int_oe_o) ##0 no_cause[*8] |-> !int_oe_o)
		else $error("brown-out raised the interrupt");
	chk_reset_release: assert property ($rose(nrst_i) |-> !int_oe_o && !sda_oe_o)
		else $error("outputs active after reset");
	chk_ack_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o[*4])
		else $error("data line released too early");
	chk_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data line moved while clock high");
	chk_open_drain: assert property (!sda_o && !int_o)
		else $error("open drain output driven high");
endmodule // light_prox_interrupt_regs_monitor

bind light_prox_interrupt_regs light_prox_interrupt_regs_monitor chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.int_o(int_o), .int_oe_o(int_oe_o), .near_valid_i(near_valid_i),
	.light_valid_i(light_valid_i), .brownout_i(brownout_i)
);

//--- light_prox_pkg.sv
package light_prox_pkg;

	// Register offsets.
	localparam logic [7:0] OFS_INT_CFG_STATUS  = 8'h04;
	localparam logic [7:0] OFS_NEAR_LOW_THR    = 8'h05;
	localparam logic [7:0] OFS_NEAR_HIGH_THR   = 8'h06;
	localparam logic [7:0] OFS_LIGHT_LOW_UPPER = 8'h07;
	localparam logic [7:0] OFS_LIGHT_SHARED    = 8'h08;
	localparam logic [7:0] OFS_LIGHT_HIGH_LOW  = 8'h09;
	localparam logic [7:0] OFS_NEAR_RESULT     = 8'h0a;
	localparam logic [7:0] OFS_LIGHT_RES_HIGH  = 8'h0b;
	localparam logic [7:0] OFS_LIGHT_RES_LOW   = 8'h0c;
	localparam logic [7:0] OFS_AMBIENT_IR      = 8'h0d;
	localparam logic [7:0] OFS_SW_RESET_CTRL   = 8'h0e;

	// Field positions in the interrupt configuration and status register.
	localparam int BIT_NEAR_FLAG     = 7;
	localparam int BIT_NEAR_PERS_HI  = 6;
	localparam int BIT_NEAR_PERS_LO  = 5;
	localparam int BIT_BROWNOUT      = 4;
	localparam int BIT_LIGHT_FLAG    = 3;
	localparam int BIT_LIGHT_PERS_HI = 2;
	localparam int BIT_LIGHT_PERS_LO = 1;
	localparam int BIT_COMBINE_AND   = 0;

	// Values after reset.
	localparam logic [7:0] RST_INT_CFG_STATUS  = 8'h10;
	localparam logic [7:0] RST_NEAR_LOW_THR    = 8'h00;
	localparam logic [7:0] RST_NEAR_HIGH_THR   = 8'hff;
	localparam logic [7:0] RST_LIGHT_LOW_UPPER = 8'h00;
	localparam logic [7:0] RST_LIGHT_SHARED    = 8'h0f;
	localparam logic [7:0] RST_LIGHT_HIGH_LOW  = 8'hff;
	localparam logic [7:0] RST_SW_RESET_CTRL   = 8'h00;
	localparam logic [7:0] RST_RESULT          = 8'h00;

	// Code that starts a software reset.
	localparam logic [7:0] SOFTWARE_RESET_CODE = 8'h38;

	// Serial bus: bits in a byte and the saturation of the event counters.
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam logic [3:0] PERSIST_MAX    = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_ADDR      = 3'b001,
		ST_ADDR_ACK  = 3'b011,
		ST_WRITE     = 3'b010,
		ST_WRITE_ACK = 3'b110,
		ST_READ      = 3'b111,
		ST_READ_ACK  = 3'b101
	} bus_state_type;

endpackage

//--- serial_host_model.sv
module serial_host_model
#(
	parameter logic [6:0] ADDR = 7'h2a
)
(
	// Serial bus lines
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int nacks = 0;

	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// Data changes mid-low and is sampled mid-high.
	task automatic bit_io(input logic drive, input logic b, output logic r);
		#40 sda_low_o = drive && !b;
		#40 scl_o = 1'b1;
		#40 r = sda_i;
		#40 scl_o = 1'b0;
	endtask
	task automatic start();
		#40 sda_low_o = 1'b0;
		#40 scl_o = 1'b1;
		#40 sda_low_o = 1'b1;
		#40 scl_o = 1'b0;
	endtask
	task automatic stop();
		#40 sda_low_o = 1'b1;
		#40 scl_o = 1'b1;
		#40 sda_low_o = 1'b0;
		#40;
	endtask
	task automatic send(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i], r);
		bit_io(1'b0, 1'b0, r);
		if (r)
			nacks++;
	endtask
	// The host acknowledges every byte but the last, which it refuses.
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b0, 1'b0, d[i]);
		bit_io(1'b1, last, r);
	endtask
	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] dat);
		write_to(ADDR, ofs, dat);
	endtask
	task automatic write_to(input logic [6:0] adr, input logic [7:0] ofs, input logic [7:0] dat);
		#3;
		start();
		send({adr, 1'b0});
		send(ofs);
		send(dat);
		stop();
	endtask
	task automatic read_reg(input logic [7:0] ofs, output logic [7:0] dat);
		#3;
		start();
		send({ADDR, 1'b0});
		send(ofs);
		start();
		send({ADDR, 1'b1});
		recv(1'b1, dat);
		stop();
	endtask
	task automatic read_pair(input logic [7:0] ofs, output logic [7:0] first, output logic [7:0] second);
		#3;
		start();
		send({ADDR, 1'b0});
		send(ofs);
		start();
		send({ADDR, 1'b1});
		recv(1'b0, first);
		recv(1'b1, second);
		stop();
	endtask
endmodule // serial_host_model

//--- test_light_prox_interrupt_regs.sv
module test_light_prox_interrupt_regs
	import light_prox_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       wr;
		logic [7:0] ofs;
		logic [7:0] dat;
		logic [7:0] exp;
	} row_type;

	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        near_valid = 1'b0;
	logic        light_valid = 1'b0;
	logic        window_mode = 1'b0;
	logic        brownout = 1'b0;
	logic [11:0] result = 12'h000;
	logic        scl;
	logic        host_low;
	logic        sda_oe;
	logic        int_oe;
	wire         sda = !(host_low || sda_oe);
	int          errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [7:0]  pair_first;
	logic [7:0]  pair_second;
	row_type     rows [17] = '{
		'{1'b0, 8'h04, 8'h00, 8'h10}, '{1'b0, 8'h05, 8'h00, 8'h00}, '{1'b0, 8'h06, 8'h00, 8'hff},
		'{1'b0, 8'h07, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h0f}, '{1'b0, 8'h09, 8'h00, 8'hff},
		'{1'b0, 8'h0e, 8'h00, 8'h00}, '{1'b0, 8'h0a, 8'h00, 8'h00}, '{1'b0, 8'h0d, 8'h00, 8'h00},
		'{1'b0, 8'h01, 8'h00, 8'h00}, '{1'b1, 8'h05, 8'ha5, 8'ha5}, '{1'b1, 8'h06, 8'hc3, 8'hc3},
		'{1'b1, 8'h07, 8'h12, 8'h12}, '{1'b1, 8'h08, 8'h34, 8'h34}, '{1'b1, 8'h09, 8'h56, 8'h56},
		'{1'b1, 8'h0b, 8'hff, 8'h00}, '{1'b1, 8'h03, 8'hff, 8'h00}
	};

	serial_host_model host (.sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

	light_prox_interrupt_regs DUT (
		.clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
		.int_o(), .int_oe_o(int_oe), .near_valid_i(near_valid), .near_result_i(result[7:0]),
		.ambient_ir_level_i(7'h55), .washout_flag_i(1'b1), .near_window_mode_i(window_mode),
		.light_valid_i(light_valid), .light_result_i(result), .brownout_i(brownout)
	);

	always #5 clk = !clk;

	task automatic end_of_test();
		$display("Checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_pin(input logic got, input logic exp);
		check_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic expect_reg(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		host.read_reg(ofs, d);
		check_byte(d, exp);
	endtask
	// One measurement strobe; the pin has settled when the task returns.
	task automatic pulse(input logic light, input logic [11:0] val);
		@(posedge clk);
		near_valid <= !light;
		light_valid <= light;
		result <= val;
		@(posedge clk);
		near_valid <= 1'b0;
		light_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (rows[i])
		begin
			if (rows[i].wr)
				host.write_reg(rows[i].ofs, rows[i].dat);
			expect_reg(rows[i].ofs, rows[i].exp);
		end
		host.read_pair(OFS_LIGHT_LOW_UPPER, pair_first, pair_second);
		check_byte(pair_first, 8'h12);
		check_byte(pair_second, 8'h34);
		host.write_to(7'h2b, OFS_NEAR_LOW_THR, 8'h77);
		expect_reg(OFS_NEAR_LOW_THR, 8'ha5);
		check_byte(8'(host.nacks), 8'h03);
		host.write_reg(OFS_INT_CFG_STATUS, 8'h00);
		expect_reg(OFS_INT_CFG_STATUS, 8'h00);
		@(posedge clk);
		brownout <= 1'b1;
		repeat (4) @(posedge clk);
		brownout <= 1'b0;
		expect_reg(OFS_INT_CFG_STATUS, 8'h10);
		check_pin(int_oe, 1'b0);
		// Each pass starts with a miss on the threshold boundary to restart the count.
		for (int ch = 0; ch < 2; ch++)
			for (int c = 0; c < 4; c++)
			begin
				host.write_reg(OFS_INT_CFG_STATUS, (ch != 0) ? 8'(c << 1) : 8'(c << 5));
				pulse(ch != 0, (ch != 0) ? 12'h123 : 12'h0c3);
				repeat ((1 << c) - 1) pulse(ch != 0, (ch != 0) ? 12'h457 : 12'h0c4);
				check_pin(int_oe, 1'b0);
				pulse(ch != 0, (ch != 0) ? 12'h457 : 12'h0c4);
				check_pin(int_oe, 1'b1);
			end
		expect_reg(OFS_INT_CFG_STATUS, 8'h0e);
		host.write_reg(OFS_INT_CFG_STATUS, 8'h01);
		check_pin(int_oe, 1'b0);
		pulse(1'b1, 12'h122);
		check_pin(int_oe, 1'b0);
		expect_reg(OFS_INT_CFG_STATUS, 8'h09);
		pulse(1'b0, 12'h0c4);
		check_pin(int_oe, 1'b1);
		expect_reg(OFS_INT_CFG_STATUS, 8'h89);
		expect_reg(OFS_AMBIENT_IR, 8'hab);
		expect_reg(OFS_NEAR_RESULT, 8'hc4);
		expect_reg(OFS_LIGHT_RES_HIGH, 8'h01);
		expect_reg(OFS_LIGHT_RES_LOW, 8'h22);
		pulse(1'b0, 12'h010);
		check_pin(int_oe, 1'b0);
		expect_reg(OFS_INT_CFG_STATUS, 8'h09);
		@(posedge clk);
		window_mode <= 1'b1;
		pulse(1'b0, 12'h010);
		check_pin(int_oe, 1'b1);
		window_mode <= 1'b0;
		host.write_reg(OFS_SW_RESET_CTRL, SOFTWARE_RESET_CODE);
		check_pin(int_oe, 1'b0);
		expect_reg(OFS_NEAR_LOW_THR, 8'h00);
		expect_reg(OFS_SW_RESET_CTRL, 8'h00);
		expect_reg(OFS_INT_CFG_STATUS, 8'h10);
		// A pending interrupt must be dropped by a reset in mid-run.
		host.write_reg(OFS_NEAR_LOW_THR, 8'h80);
		@(posedge clk);
		window_mode <= 1'b1;
		pulse(1'b0, 12'h010);
		check_pin(int_oe, 1'b1);
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		window_mode <= 1'b0;
		repeat (4) @(posedge clk);
		check_pin(int_oe, 1'b0);
		expect_reg(OFS_NEAR_LOW_THR, 8'h00);
		expect_reg(OFS_INT_CFG_STATUS, 8'h10);
		check_byte(8'(host.nacks), 8'h03);
		end_of_test();
	end
endmodule // test_light_prox_interrupt_regs
